// ### src/control_link_master.sv
// register file and command framing of the control serial link master
`timescale 1ns/100ps
`default_nettype none
module control_link_master
  import link_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // control serial link
  output var  logic        link_clk,
  output var  logic        link_txd,
  input  wire logic        link_rxd,
  // port pins
  input  wire logic [15:0] porta_in,
  output var  logic [15:0] porta_out,
  output var  logic [15:0] porta_oe_n,
  // transceiver interrupt and requests onward
  input  wire logic        level_one_irq_input_n,
  output var  logic        level_one_irq_req,
  output var  logic        modem_change_req
);
  link_if lk ();

  logic        pend_r;
  logic        pend_wr_r;
  logic [7:0]  pend_addr_r;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  mode_r;
  logic [13:0] desc_r;
  logic [15:0] func_r;
  logic [15:0] dir_r;
  logic [15:0] level_r;
  logic [15:0] read_level;
  logic        delta;
  logic        done_r;
  logic        nt_side_r;
  logic [2:0]  sel;
  logic [1:0]  pre_kind;
  logic [3:0]  pre_addr;
  logic [7:0]  pre_data;
  logic [16:0] pre_frame;
  logic        start_ok;
  logic [31:0] rd_nxt;

  // builds the command bytes of one register access
  function automatic logic [16:0] frame(input logic [1:0] kind,
                                        input logic [3:0] addr,
                                        input logic [7:0] data);
    logic [16:0] f;
    f = 17'h00000;
    case (kind)
      KIND_NIB_WR:  f = {1'b0, NIB_WR_FLAG, addr[2:0], data[3:0], 8'h00};
      KIND_NIB_RD:  f = {1'b0, NIB_RD_FLAG, addr[2:0], 4'h0, 8'h00};
      KIND_BYTE_WR: f = {1'b1, BYTE_WR_PREFIX, addr, data};
      default:      f = {1'b1, BYTE_RD_PREFIX, addr, 8'h00};
    endcase
    return f;
  endfunction : frame

  // bus: every access takes one wait state so read data leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r      <= 1'b0;
      pend_wr_r   <= 1'b0;
      pend_addr_r <= 8'h00;
      hreadyout   <= 1'b1;
    end else if (hsel && hready && htrans[1]) begin
      pend_r      <= 1'b1;
      pend_wr_r   <= hwrite;
      pend_addr_r <= haddr[7:0];
      hreadyout   <= 1'b0;
    end else begin
      pend_r    <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  assign wr_en = pend_r && pend_wr_r;
  assign rd_en = pend_r && !pend_wr_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_en) begin
      hrdata <= rd_nxt;
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    if (pend_addr_r == REG_LINK_MODE) begin
      rd_nxt = {24'h000000, mode_r};
    end else if (pend_addr_r == REG_LINK_DESC) begin
      rd_nxt = {18'h00000, desc_r};
    end else if (pend_addr_r == REG_LINK_START) begin
      rd_nxt = {31'h00000000, lk.busy};
    end else if (pend_addr_r == REG_LINK_RX) begin
      rd_nxt = {16'h0000, lk.rx};
    end else if (pend_addr_r == REG_PORT_FUNC) begin
      rd_nxt = {16'h0000, func_r};
    end else if (pend_addr_r == REG_PORT_DIR) begin
      rd_nxt = {16'h0000, dir_r};
    end else if (pend_addr_r == REG_PORT_LEVEL) begin
      rd_nxt = {16'h0000, read_level};
    end else if (pend_addr_r == REG_STATUS) begin
      rd_nxt = {28'h0000000, level_one_irq_req, modem_change_req, done_r, lk.busy};
    end
  end

  // link mode and descriptor
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_RESET;
    end else if (wr_en && pend_addr_r == REG_LINK_MODE) begin
      mode_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_r <= DESC_RESET;
    end else if (wr_en && pend_addr_r == REG_LINK_DESC) begin
      desc_r <= hwdata[13:0];
    end
  end

  assign lk.invert = (mode_r == MODE_INV_DIV32);

  // port registers; the select line and the transceiver reset are port pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_r  <= PORT_RESET;
      dir_r   <= PORT_RESET;
      level_r <= PORT_RESET;
    end else if (wr_en) begin
      if (pend_addr_r == REG_PORT_FUNC) begin
        func_r <= hwdata[15:0];
      end else if (pend_addr_r == REG_PORT_DIR) begin
        dir_r <= hwdata[15:0];
      end else if (pend_addr_r == REG_PORT_LEVEL) begin
        level_r <= hwdata[15:0];
      end
    end
  end

  // preset selection: built-in transceiver set-up commands
  assign sel = hwdata[PRESET_LSB +: 3];

  always_comb begin
    pre_kind = desc_r[DESC_KIND_LSB +: 2];
    pre_addr = desc_r[DESC_ADDR_LSB +: 4];
    pre_data = desc_r[DESC_DATA_LSB +: 8];
    case (sel)
      PRE_NT_INIT: begin
        pre_kind = KIND_BYTE_WR;
        pre_addr = BYTE_REG_SEVEN;
        pre_data = BYTE_SEVEN_NT;
      end
      PRE_TE_INIT: begin
        pre_kind = KIND_BYTE_WR;
        pre_addr = BYTE_REG_SEVEN;
        pre_data = BYTE_SEVEN_TE;
      end
      PRE_TE_BEARER: begin
        pre_kind = KIND_NIB_WR;
        pre_addr = NIB_BEARER;
        pre_data = NIB_BEARER_ON;
      end
      PRE_ACTIVATE: begin
        pre_kind = KIND_NIB_WR;
        pre_addr = NIB_ACTIVATION;
        pre_data = NIB_ACT;
      end
      PRE_DEACTIVATE: begin
        pre_kind = KIND_NIB_WR;
        pre_addr = NIB_ACTIVATION;
        pre_data = NIB_DEACT;
      end
      default: begin
        pre_kind = desc_r[DESC_KIND_LSB +: 2];
      end
    endcase
  end

  assign pre_frame = frame(pre_kind, pre_addr, pre_data);

  // a start while busy, or a deactivation off the network side, is dropped
  assign start_ok = wr_en && (pend_addr_r == REG_LINK_START) && hwdata[START_BIT] &&
                    !lk.busy && !lk.start &&
                    !((sel == PRE_DEACTIVATE) && !nt_side_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk.start <= 1'b0;
      lk.two   <= 1'b0;
      lk.tx    <= 16'h0000;
    end else begin
      lk.start <= start_ok;
      if (start_ok) begin
        lk.two <= pre_frame[16];
        lk.tx  <= pre_frame[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nt_side_r <= 1'b0;
    end else if (start_ok && sel == PRE_NT_INIT) begin
      nt_side_r <= 1'b1;
    end else if (start_ok && sel == PRE_TE_INIT) begin
      nt_side_r <= 1'b0;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (lk.done) begin
      done_r <= 1'b1;
    end else if (wr_en && pend_addr_r == REG_STATUS && hwdata[STAT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_change_req <= 1'b0;
    end else if (delta) begin
      modem_change_req <= 1'b1;
    end else if (wr_en && pend_addr_r == REG_STATUS && hwdata[STAT_DELTA]) begin
      modem_change_req <= 1'b0;
    end
  end

  // the transceiver line is active low; passed on as a level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_one_irq_req <= 1'b0;
    end else begin
      level_one_irq_req <= ~level_one_irq_input_n;
    end
  end

  link_shifter u_shifter (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .lk       (lk.engine),
    .link_clk (link_clk),
    .link_txd (link_txd),
    .link_rxd (link_rxd)
  );

  port_pins u_port (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .func       (func_r),
    .dir        (dir_r),
    .level      (level_r),
    .pin_in     (porta_in),
    .pin_out    (porta_out),
    .pin_oe_n   (porta_oe_n),
    .read_level (read_level),
    .delta      (delta)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_wait_state;
    (hsel && hready && htrans[1]) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("bus wait state wrong");

  property p_start_cause;
    lk.start |-> $past(wr_en && pend_addr_r == REG_LINK_START && hwdata[START_BIT]);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without start bit");

  property p_busy_follows;
    lk.start |=> lk.busy;
  endproperty
  a_busy_follows: assert property (p_busy_follows) else $error("no exchange after start");

  property p_nt_frame;
    $past(start_ok && sel == PRE_NT_INIT) |->
      (lk.start && lk.two && lk.tx == {BYTE_WR_PREFIX, BYTE_REG_SEVEN, BYTE_SEVEN_NT});
  endproperty
  a_nt_frame: assert property (p_nt_frame) else $error("network init frame wrong");

  property p_te_bearer;
    $past(start_ok && sel == PRE_TE_BEARER) |->
      (!lk.two && lk.tx == {NIB_WR_FLAG, NIB_BEARER[2:0], NIB_BEARER_ON[3:0], 8'h00});
  endproperty
  a_te_bearer: assert property (p_te_bearer) else $error("bearer enable frame wrong");

  property p_activate;
    $past(start_ok && sel == PRE_ACTIVATE) |->
      (!lk.two && lk.tx[15:8] == {NIB_WR_FLAG, NIB_ACTIVATION[2:0], NIB_ACT[3:0]});
  endproperty
  a_activate: assert property (p_activate) else $error("activation frame wrong");

  property p_deact_refused;
    (wr_en && pend_addr_r == REG_LINK_START && sel == PRE_DEACTIVATE && !nt_side_r)
      |=> !lk.start;
  endproperty
  a_deact_refused: assert property (p_deact_refused) else $error("deactivation off net side");

  property p_byte_read;
    $past(start_ok && pre_kind == KIND_BYTE_RD) |->
      (lk.two && lk.tx[15:12] == BYTE_RD_PREFIX && lk.tx[7:0] == 8'h00);
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read frame wrong");

  property p_nib_read;
    $past(start_ok && pre_kind == KIND_NIB_RD) |-> (!lk.two && lk.tx[15] == NIB_RD_FLAG);
  endproperty
  a_nib_read: assert property (p_nib_read) else $error("nibble read frame wrong");

  property p_irq_level;
    level_one_irq_req == !$past(level_one_irq_input_n);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level not passed");

  // a clear written right after the event may drop the flag one cycle later
  property p_done_sticky;
    lk.done |=> (done_r ##1
      (done_r || $past(wr_en && pend_addr_r == REG_STATUS && hwdata[STAT_DONE])));
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");
endmodule : control_link_master
`default_nettype wire

// ### src/link_pkg.sv
// constants and types for the control serial link master
// Behaviour
// - four wires: txd, rxd, clock, select line
// - this block makes clock and select
// - software raises select around each exchange
// - mode 2F: clock idles high, inverted
// - link clock is system clock over 32
// - exchange starts only on start bit
// - nibble write: 0, address, data
// - nibble read: 1, address, four ignored
// - byte write sends two bytes
// - byte read: F and address, filler
// - transceiver interrupt taken at level one
// - transceiver reset from a port output
// - polled setup: function 000B, direction 01A4
// - polled modem lines read, no event
// - dedicated setup 005B flags modem changes
// - network side: byte seven gets 0C
// - terminal side: 04 and nibble five C
// - activation writes 8, deactivation 4
package link_pkg;
  localparam logic [7:0]  REG_LINK_MODE   = 8'h00;
  localparam logic [7:0]  REG_LINK_DESC   = 8'h04;
  localparam logic [7:0]  REG_LINK_START  = 8'h08;
  localparam logic [7:0]  REG_LINK_RX     = 8'h0C;
  localparam logic [7:0]  REG_PORT_FUNC   = 8'h10;
  localparam logic [7:0]  REG_PORT_DIR    = 8'h14;
  localparam logic [7:0]  REG_PORT_LEVEL  = 8'h18;
  localparam logic [7:0]  REG_STATUS      = 8'h1C;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  MODE_INV_DIV32  = 8'h2F;
  localparam int          LINK_DIV        = 32;
  localparam logic [3:0]  HALF_LAST       = 4'(LINK_DIV / 2 - 1);
  localparam logic [4:0]  BITS_ONE        = 5'h08;
  localparam logic [4:0]  BITS_TWO        = 5'h10;
  localparam int          START_BIT       = 0;
  localparam int          PRESET_LSB      = 1;
  localparam int          DESC_ADDR_LSB   = 0;
  localparam int          DESC_DATA_LSB   = 4;
  localparam int          DESC_KIND_LSB   = 12;
  localparam logic [13:0] DESC_RESET      = 14'h0000;
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_DONE       = 1;
  localparam int          STAT_DELTA      = 2;
  localparam int          STAT_IRQ        = 3;
  localparam logic [1:0]  KIND_NIB_WR     = 2'h0;
  localparam logic [1:0]  KIND_NIB_RD     = 2'h1;
  localparam logic [1:0]  KIND_BYTE_WR    = 2'h2;
  localparam logic [1:0]  KIND_BYTE_RD    = 2'h3;
  localparam logic [2:0]  PRE_DESC        = 3'h0;
  localparam logic [2:0]  PRE_NT_INIT     = 3'h1;
  localparam logic [2:0]  PRE_TE_INIT     = 3'h2;
  localparam logic [2:0]  PRE_TE_BEARER   = 3'h3;
  localparam logic [2:0]  PRE_ACTIVATE    = 3'h4;
  localparam logic [2:0]  PRE_DEACTIVATE  = 3'h5;
  localparam logic        NIB_WR_FLAG     = 1'b0;
  localparam logic        NIB_RD_FLAG     = 1'b1;
  localparam logic [3:0]  BYTE_RD_PREFIX  = 4'hF;
  localparam logic [3:0]  BYTE_WR_PREFIX  = 4'hE;
  localparam logic [3:0]  BYTE_REG_SEVEN  = 4'h7;
  localparam logic [7:0]  BYTE_SEVEN_NT   = 8'h0C;
  localparam logic [7:0]  BYTE_SEVEN_TE   = 8'h04;
  localparam logic [3:0]  NIB_ACTIVATION  = 4'h2;
  localparam logic [3:0]  NIB_BEARER      = 4'h5;
  localparam logic [7:0]  NIB_ACT         = 8'h08;
  localparam logic [7:0]  NIB_DEACT       = 8'h04;
  localparam logic [7:0]  NIB_BEARER_ON   = 8'h0C;
  localparam int          PIN_LINK_SELECT = 7;
  localparam int          PIN_XCVR_RESET  = 8;
  localparam int          PIN_MODEM_A     = 4;
  localparam int          PIN_MODEM_B     = 6;
  localparam logic [15:0] FUNC_POLLED     = 16'h000B;
  localparam logic [15:0] FUNC_DEDICATED  = 16'h005B;
  localparam logic [15:0] DIR_MODEM       = 16'h01A4;
  localparam logic [15:0] PORT_RESET      = 16'h0000;
  typedef enum logic {LINK_IDLE, LINK_RUN} link_state_type;
endpackage : link_pkg

// ### src/link_if.sv
// control and status between register file and link shifter
`timescale 1ns/100ps
`default_nettype none
interface link_if;
  logic        start;
  logic        two;
  logic        invert;
  logic [15:0] tx;
  logic [15:0] rx;
  logic        busy;
  logic        done;
  modport ctrl   (output start, two, invert, tx, input rx, busy, done);
  modport engine (input start, two, invert, tx, output rx, busy, done);
endinterface : link_if
`default_nettype wire

// ### src/link_shifter.sv
// bit engine of the control serial link
`timescale 1ns/100ps
`default_nettype none
module link_shifter
  import link_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // register side
  link_if.engine    lk,
  // link pins
  output var  logic link_clk,
  output var  logic link_txd,
  input  wire logic link_rxd
);
  link_state_type state_r;
  logic [3:0]     div_r;
  logic [4:0]     bits_r;
  logic [15:0]    shift_r;
  logic           inv_r;
  logic           phase_r;
  logic           tick;

  assign tick = (state_r == LINK_RUN) && (div_r == HALF_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= LINK_IDLE;
      div_r   <= 4'h0;
      phase_r <= 1'b0;
      bits_r  <= 5'h00;
      lk.busy <= 1'b0;
      lk.done <= 1'b0;
    end else begin
      lk.done <= 1'b0;
      case (state_r)
        LINK_IDLE: begin
          if (lk.start) begin
            state_r <= LINK_RUN;
            div_r   <= 4'h0;
            phase_r <= 1'b0;
            bits_r  <= lk.two ? BITS_TWO : BITS_ONE;
            lk.busy <= 1'b1;
          end
        end
        LINK_RUN: begin
          if (tick) begin
            div_r   <= 4'h0;
            phase_r <= ~phase_r;
            if (phase_r) begin
              bits_r <= bits_r - 5'h01;
              if (bits_r == 5'h01) begin
                state_r <= LINK_IDLE;
                lk.busy <= 1'b0;
                lk.done <= 1'b1;
              end
            end
          end else begin
            div_r <= div_r + 4'h1;
          end
        end
        default: state_r <= LINK_IDLE;
      endcase
    end
  end

  // polarity is latched so a mode write mid exchange cannot glitch the clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r  <= 16'h0000;
      inv_r    <= 1'b0;
      link_txd <= 1'b0;
      lk.rx    <= 16'h0000;
    end else if (state_r == LINK_IDLE && lk.start) begin
      shift_r <= lk.tx;
      inv_r   <= lk.invert;
      lk.rx   <= 16'h0000;
    end else if (tick && !phase_r) begin
      link_txd <= shift_r[15];
      shift_r  <= {shift_r[14:0], 1'b0};
    end else if (tick) begin
      lk.rx <= {lk.rx[14:0], link_rxd};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_clk <= 1'b0;
    end else if (state_r == LINK_IDLE) begin
      link_clk <= lk.invert;
    end else if (tick) begin
      link_clk <= inv_r ^ ~phase_r;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_half_period;
    ($changed(link_clk) && lk.busy) |-> ##16 $changed(link_clk);
  endproperty
  a_half_period: assert property (p_half_period) else $error("link clock half period wrong");

  property p_idle_level;
    (!lk.busy && $past(!lk.busy)) |-> (link_clk == $past(lk.invert));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

  property p_msb_first;
    (lk.start && !lk.busy) |-> ##17 (link_txd == $past(lk.tx[15], 17));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb");

  property p_one_byte_len;
    (lk.start && !lk.busy && !lk.two) |-> ##257 lk.done;
  endproperty
  a_one_byte_len: assert property (p_one_byte_len) else $error("one byte exchange length wrong");
endmodule : link_shifter
`default_nettype wire

// ### src/port_pins.sv
// general purpose port pins with modem change detect
`timescale 1ns/100ps
`default_nettype none
module port_pins
  import link_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // settings
  input  wire logic [15:0] func,
  input  wire logic [15:0] dir,
  input  wire logic [15:0] level,
  // pins
  input  wire logic [15:0] pin_in,
  output var  logic [15:0] pin_out,
  output var  logic [15:0] pin_oe_n,
  // readback and events
  output var  logic [15:0] read_level,
  output var  logic        delta
);
  logic [1:0] modem_prev_r;

  for (genvar i = 0; i < 16; i++) begin : g_pin
    // dedicated pins belong to the serial channel and are released here
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_out[i]  <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end else begin
        pin_out[i]  <= level[i];
        pin_oe_n[i] <= ~(dir[i] & ~func[i]);
      end
    end
    assign read_level[i] = (dir[i] & ~func[i]) ? level[i] : pin_in[i];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_prev_r <= 2'b00;
      delta        <= 1'b0;
    end else begin
      modem_prev_r <= {pin_in[PIN_MODEM_B], pin_in[PIN_MODEM_A]};
      delta <= (func[PIN_MODEM_A] & (pin_in[PIN_MODEM_A] ^ modem_prev_r[0])) |
               (func[PIN_MODEM_B] & (pin_in[PIN_MODEM_B] ^ modem_prev_r[1]));
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_drive;
    ($past(dir[PIN_LINK_SELECT]) && !$past(func[PIN_LINK_SELECT])) |->
      (!pin_oe_n[PIN_LINK_SELECT] && pin_out[PIN_LINK_SELECT] == $past(level[PIN_LINK_SELECT]));
  endproperty
  a_drive: assert property (p_drive) else $error("select pin not driven from level");

  property p_release;
    ((~pin_oe_n) & $past(func)) == 16'h0000;
  endproperty
  a_release: assert property (p_release) else $error("dedicated pin driven");

  property p_delta;
    (func[PIN_MODEM_A] && $changed(pin_in[PIN_MODEM_A])) |=> delta;
  endproperty
  a_delta: assert property (p_delta) else $error("modem change missed");

  property p_polled;
    ($past(func) == FUNC_POLLED) |-> !delta;
  endproperty
  a_polled: assert property (p_polled) else $error("event in polled setup");
endmodule : port_pins
`default_nettype wire

// ### tb/xcvr_model.sv
// transceiver model at the far end of the control serial link
`timescale 1ns/100ps
`default_nettype none
module xcvr_model (
  // link pins
  input  wire logic        link_clk,
  input  wire logic        link_txd,
  input  wire logic        sel,
  input  wire logic        rst_n,
  output var  logic        link_rxd,
  // bits captured from the master
  output var  logic [15:0] got
);
  logic [7:0] sh_r = 8'hA5;
  initial link_rxd = 1'b0;
  always @(posedge link_clk or negedge rst_n)
    if (!rst_n) got <= 16'h0000;
    else if (sel) got <= {got[14:0], link_txd};
  // the reply rotates, so a second byte repeats it
  always @(negedge link_clk or negedge sel)
    if (!sel) begin
      link_rxd <= ~link_rxd; // released line never keeps its last level
      sh_r <= 8'hA5;
    end else begin
      link_rxd <= sh_r[7];
      sh_r <= {sh_r[6:0], sh_r[7]};
    end
endmodule : xcvr_model
`default_nettype wire

// ### tb/serial_control_port_master_bench.sv
// self-checking bench of the control serial link master
`timescale 1ns/100ps
`default_nettype none
module serial_control_port_master_bench;
  import link_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_n = 1'b1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] pin = 16'h0, pout, poe_n, got;
  logic        hrdy, hresp, lclk, ltxd, lrxd, irq_req, mreq;
  int          fails = 0, total_checks = 0, lowcnt = 0, n, k;
  always #10 hclk = ~hclk;
  always @(posedge hclk) lowcnt <= lowcnt + int'(lclk === 1'b0);
  control_link_master dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .link_clk(lclk), .link_txd(ltxd),
    .link_rxd(lrxd), .porta_in(pin), .porta_out(pout), .porta_oe_n(poe_n),
    .level_one_irq_input_n(irq_n), .level_one_irq_req(irq_req), .modem_change_req(mreq));
  xcvr_model partner (.link_clk(lclk), .link_txd(ltxd), .sel(pout[PIN_LINK_SELECT]),
    .rst_n(pout[PIN_XCVR_RESET]), .link_rxd(lrxd), .got(got));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task t_ports;
    chk(poe_n, 16'hFFFF);
    bus(1'b1, REG_PORT_FUNC, FUNC_POLLED);
    bus(1'b1, REG_PORT_DIR, DIR_MODEM);
    bus(1'b1, REG_PORT_LEVEL, 32'h0100);
    pin <= 16'h0050;
    bus(1'b0, REG_PORT_LEVEL, 32'h0);
    chk(poe_n, 16'hFE5B);
    chk(q, 32'h0150);
    chk(mreq, 1'b0);
    chk({15'h0000, hresp, pout}, 32'h0100);
    bus(1'b1, REG_PORT_FUNC, FUNC_DEDICATED);
    pin <= 16'h0040;
    repeat (3) @(posedge hclk);
    chk(mreq, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[STAT_DELTA], 1'b1);
    $display("ports test done");
  endtask : t_ports
  task t_irq;
    irq_n <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(irq_req, 1'b1);
    chk(q[STAT_IRQ], 1'b1);
    irq_n <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(irq_req, 1'b0);
    $display("irq test done");
  endtask : t_irq
  task t_link;
    // preset codes first, then plain descriptors of read and write kinds
    logic [3:0]  st [8] = '{4'h5, 4'h7, 4'h9, 4'h3, 4'hB, 4'h1, 4'h1, 4'h1};
    logic [13:0] ds [8] = '{14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
                            14'h1003, 14'h3004, 14'h25A7};
    logic [15:0] ex [8] = '{16'hE704, 16'h5C, 16'h28, 16'hE70C, 16'h24, 16'hB0, 16'hF400, 16'hE75A};
    int          nb [8] = '{2, 1, 1, 2, 1, 1, 2, 2};
    bus(1'b1, REG_LINK_MODE, MODE_INV_DIV32);
    repeat (2) @(posedge hclk);
    chk(lclk, 1'b1);
    // deactivation before any network side init must not start an exchange
    n = lowcnt;
    bus(1'b1, REG_LINK_START, 32'hB);
    repeat (40) @(posedge hclk);
    chk(lowcnt - n, 0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, REG_PORT_LEVEL, 32'h0180);
      bus(1'b1, REG_LINK_DESC, ds[i]);
      n = lowcnt;
      bus(1'b1, REG_LINK_START, st[i]);
      k = 0;
      do begin
        bus(1'b0, REG_STATUS, 32'h0);
        k++;
      end while (q[STAT_BUSY] !== 1'b0 && k < 400);
      chk(q[STAT_BUSY], 1'b0);
      chk(lowcnt - n, 128 * nb[i]);
      bus(1'b1, REG_PORT_LEVEL, 32'h0100);
      chk(nb[i] == 2 ? got : got[7:0], ex[i]);
      bus(1'b0, REG_LINK_RX, 32'h0);
      chk(nb[i] == 2 ? q[15:0] : q[7:0], nb[i] == 2 ? 16'hA5A5 : 16'hA5);
    end
    chk(lclk, 1'b1);
    n = lowcnt;
    bus(1'b1, REG_LINK_START, 32'h8);
    repeat (300) @(posedge hclk);
    chk(lowcnt - n, 0);
    $display("link test done");
  endtask : t_link
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_ports;
    t_irq;
    t_link;
    final_report;
  end
  // eight exchanges of at most 600 cycles each, with a wide margin
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    final_report;
  end
endmodule : serial_control_port_master_bench
`default_nettype wire
